// >>> serial_eeprom_defs.vh
// constants for the three-wire serial eeprom slave
`ifndef SERIAL_EEPROM_DEFS_VH
`define SERIAL_EEPROM_DEFS_VH
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_ERASE 2'h3
`define OP_EXT 2'h0
`define EXT_LOCK 2'h0
`define EXT_CLEAR 2'h2
`define EXT_FILL 2'h1
`define EXT_UNLOCK 2'h3
`define PROG_TIME_US 4000
`define CLK_MHZ 25
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define ERASED_WORD 16'hFFFF
`endif

// >>> small_fifo.v
// small valid/ready fifo carrying received words to the program engine
`timescale 1ns/1ps
module small_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ff] <= in_data_i;
    end
  end
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// >>> serial_eeprom.v
// three-wire serial eeprom slave: command decode, array, self-timed programming
`timescale 1ns/1ps
`include "serial_eeprom_defs.vh"
module serial_eeprom #(
  parameter WORD_ADDR_BITS = 10,
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter FIFO_DEPTH = 4
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire supply_ok_i,
  input wire select_i,
  input wire shift_clk_i,
  input wire data_in_i,
  input wire org_word_i,
  output reg data_out_o,
  output reg data_out_oe_o,
  output wire busy_o,
  output wire unlocked_o
);
  localparam BA = WORD_ADDR_BITS + 1;
  localparam CW = 6;
  localparam S_IDLE = 3'h0;
  localparam S_OP = 3'h1;
  localparam S_ADDR = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_READ = 3'h4;
  localparam S_DONE = 3'h5;
  localparam K_WRITE = 2'h0;
  localparam K_ERASE = 2'h1;
  localparam K_CLEAR = 2'h2;
  localparam K_FILL = 2'h3;
  localparam FW = 2 + BA + 16;

  reg [7:0] mem_lo [0:(1<<WORD_ADDR_BITS)-1];
  reg [7:0] mem_hi [0:(1<<WORD_ADDR_BITS)-1];

  reg [2:0] sel_sync_ff;
  reg [2:0] clk_sync_ff;
  reg [1:0] din_sync_ff;
  reg [1:0] org_sync_ff;
  reg [1:0] sup_sync_ff;
  reg [2:0] state_ff;
  reg [CW-1:0] cnt_ff;
  reg [1:0] op_ff;
  reg [BA-1:0] addr_ff;
  reg [15:0] shreg_ff;
  reg word_mode_ff;
  reg unlock_ff;
  reg busy_ff;
  reg [31:0] prog_cnt_ff;
  reg [1:0] pkind_ff;
  reg [BA-1:0] paddr_ff;
  reg [15:0] pdata_ff;
  reg [BA:0] sweep_ff;
  reg push_ff;
  reg [FW-1:0] push_data_ff;

  wire sel;
  wire din;
  wire active;
  wire clk_rise;
  wire in_ready;
  wire out_valid;
  wire [FW-1:0] out_data;
  wire [CW-1:0] addr_len;
  wire [CW-1:0] data_len;
  wire [BA-1:0] addr_max;
  wire [BA-1:0] next_addr;
  wire start_ok;
  wire sweep_done;

  // byte mode returns the byte in the upper half so its msb leads the shift
  function [15:0] fetch;
    input [BA-1:0] a;
    input wm;
    begin
      if (wm) begin
        fetch = {mem_hi[a[BA-2:0]], mem_lo[a[BA-2:0]]};
      end else if (a[0]) begin
        fetch = {mem_hi[a[BA-1:1]], 8'h00};
      end else begin
        fetch = {mem_lo[a[BA-1:1]], 8'h00};
      end
    end
  endfunction

  // address register after one more serial bit; word mode keeps the top bit clear
  function [BA-1:0] shift_addr;
    input [BA-1:0] a;
    input wm;
    input b;
    begin
      if (wm) begin
        shift_addr = {1'b0, a[BA-3:0], b};
      end else begin
        shift_addr = {a[BA-2:0], b};
      end
    end
  endfunction

  assign sel = sel_sync_ff[1];
  assign din = din_sync_ff[1];
  assign clk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
  assign active = sup_sync_ff[1] & sel;
  assign addr_len = word_mode_ff ? WORD_ADDR_BITS[CW-1:0] : BA[CW-1:0];
  assign data_len = word_mode_ff ? 6'h10 : 6'h08;
  assign addr_max = word_mode_ff ? {1'b0, {(BA-1){1'b1}}} : {BA{1'b1}};
  assign next_addr = (addr_ff == addr_max) ? {BA{1'b0}} : addr_ff + 1'b1;
  assign busy_o = busy_ff;
  assign unlocked_o = unlock_ff;
  // a start bit is refused while any program work is still pending
  assign start_ok = ~busy_ff & ~push_ff & ~out_valid;
  // a short program timer is stretched until clear or fill has covered every word
  assign sweep_done = sweep_ff[BA-1];

  // pins cross on two flops; the shift clock keeps a third only for edge finding
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sel_sync_ff <= 3'h0;
      clk_sync_ff <= 3'h0;
      din_sync_ff <= 2'h0;
      org_sync_ff <= 2'h0;
      sup_sync_ff <= 2'h0;
    end else begin
      sel_sync_ff <= {sel_sync_ff[1:0], select_i};
      clk_sync_ff <= {clk_sync_ff[1:0], shift_clk_i};
      din_sync_ff <= {din_sync_ff[0], data_in_i};
      org_sync_ff <= {org_sync_ff[0], org_word_i};
      sup_sync_ff <= {sup_sync_ff[0], supply_ok_i};
    end
  end

  // command shifter
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= {CW{1'b0}};
      op_ff <= 2'h0;
      addr_ff <= {BA{1'b0}};
      shreg_ff <= 16'h0000;
      word_mode_ff <= 1'b1;
      unlock_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= {FW{1'b0}};
    end else begin
      // a pushed entry is held until the fifo takes it
      push_ff <= push_ff & ~in_ready;
      // supply drop stops any response at once
      if (!sup_sync_ff[1]) begin
        state_ff <= S_IDLE;
        unlock_ff <= 1'b0;
      end else if (!active) begin
        state_ff <= S_IDLE;
      end else if (clk_rise) begin
        case (state_ff)
          S_IDLE: begin
            if (din && start_ok) begin
              state_ff <= S_OP;
              cnt_ff <= 6'h02;
              word_mode_ff <= org_sync_ff[1];
            end
          end
          S_OP: begin
            op_ff <= {op_ff[0], din};
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == 6'h01) begin
              state_ff <= S_ADDR;
              cnt_ff <= addr_len;
            end
          end
          S_ADDR: begin
            addr_ff <= shift_addr(addr_ff, word_mode_ff, din);
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == 6'h01) begin
              cnt_ff <= data_len;
              state_ff <= S_DONE;
              if (op_ff == `OP_READ) begin
                state_ff <= S_READ;
                shreg_ff <= 16'h0000;
                cnt_ff <= 6'h01;
              end else if (op_ff == `OP_WRITE) begin
                state_ff <= S_DATA;
              end else if (op_ff == `OP_ERASE) begin
                push_ff <= unlock_ff;
                push_data_ff <= {K_ERASE, shift_addr(addr_ff, word_mode_ff, din), `ERASED_WORD};
              end else begin
                // the code sits in the first two address bits, already inside addr_ff here
                case (word_mode_ff ? {addr_ff[BA-3], addr_ff[BA-4]} : {addr_ff[BA-2], addr_ff[BA-3]})
                  `EXT_UNLOCK: unlock_ff <= 1'b1;
                  `EXT_LOCK: unlock_ff <= 1'b0;
                  `EXT_CLEAR: begin
                    push_ff <= unlock_ff;
                    push_data_ff <= {K_CLEAR, {BA{1'b0}}, `ERASED_WORD};
                  end
                  `EXT_FILL: state_ff <= S_DATA;
                  default: state_ff <= S_DONE;
                endcase
              end
            end
          end
          S_DATA: begin
            shreg_ff <= {shreg_ff[14:0], din};
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == 6'h01) begin
              state_ff <= S_DONE;
              push_ff <= unlock_ff;
              push_data_ff <= {(op_ff == `OP_WRITE) ? K_WRITE : K_FILL, addr_ff,
                (word_mode_ff ? {shreg_ff[14:0], din} : {shreg_ff[6:0], din, 8'h00})};
            end
          end
          S_READ: begin
            if (cnt_ff == 6'h01) begin
              shreg_ff <= fetch(addr_ff, word_mode_ff);
              addr_ff <= next_addr;
              cnt_ff <= data_len;
            end else begin
              shreg_ff <= {shreg_ff[14:0], 1'b0};
              cnt_ff <= cnt_ff - 1'b1;
            end
          end
          default: state_ff <= state_ff;
        endcase
      end
    end
  end

  // serial output: read data, busy status, or released
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_out_o <= 1'b0;
      data_out_oe_o <= 1'b0;
    end else begin
      data_out_oe_o <= active & ((state_ff == S_READ) | (state_ff == S_IDLE) | (state_ff == S_DONE));
      if (state_ff == S_READ) begin
        data_out_o <= shreg_ff[15];
      end else begin
        // busy low, ready high
        // ready only once nothing waits to be programmed
        data_out_o <= start_ok;
      end
    end
  end

  // entries pass through here one at a time; none arrives while a program cycle runs
  small_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) i_small_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push_ff),
    .in_ready_o(in_ready),
    .in_data_i(push_data_ff),
    .out_valid_o(out_valid),
    .out_ready_i(~busy_ff),
    .out_data_o(out_data)
  );

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      prog_cnt_ff <= 32'h0;
      pkind_ff <= 2'h0;
      paddr_ff <= {BA{1'b0}};
      pdata_ff <= 16'h0000;
      sweep_ff <= {(BA+1){1'b0}};
    end else if (!busy_ff) begin
      if (out_valid) begin
        busy_ff <= 1'b1;
        // counting down to zero gives PROG_CYCLES cycles of busy
        prog_cnt_ff <= PROG_CYCLES - 1;
        pkind_ff <= out_data[FW-1:FW-2];
        paddr_ff <= out_data[FW-3:16];
        pdata_ff <= out_data[15:0];
        sweep_ff <= {(BA+1){1'b0}};
      end
    end else if (pkind_ff == K_CLEAR || pkind_ff == K_FILL) begin
      if (sweep_ff[BA-1] == 1'b0) begin
        mem_lo[sweep_ff[BA-2:0]] <= word_mode_ff ? pdata_ff[7:0] : pdata_ff[15:8];
        mem_hi[sweep_ff[BA-2:0]] <= pdata_ff[15:8];
        sweep_ff <= sweep_ff + 1'b1;
      end
      // busy ends only when both the timer and the sweep are done
      if (prog_cnt_ff != 32'h0) begin
        prog_cnt_ff <= prog_cnt_ff - 1'b1;
      end else if (sweep_done) begin
        busy_ff <= 1'b0;
      end
    end else begin
      // a single location lands when the timer runs out
      if (prog_cnt_ff == 32'h0) begin
        busy_ff <= 1'b0;
        if (word_mode_ff) begin
          mem_lo[paddr_ff[BA-2:0]] <= pdata_ff[7:0];
          mem_hi[paddr_ff[BA-2:0]] <= pdata_ff[15:8];
        end else if (paddr_ff[0]) begin
          mem_hi[paddr_ff[BA-1:1]] <= pdata_ff[15:8];
        end else begin
          mem_lo[paddr_ff[BA-1:1]] <= pdata_ff[15:8];
        end
      end else begin
        prog_cnt_ff <= prog_cnt_ff - 1'b1;
      end
    end
  end
endmodule

// >>> serial_eeprom_monitor.sv
// port checker for the serial eeprom slave
`timescale 1ns/1ps
module serial_eeprom_monitor (
  input wire mclk_i,
  input wire rst_n_i,
  input wire supply_ok_i,
  input wire select_i,
  input wire shift_clk_i,
  input wire data_out_o,
  input wire data_out_oe_o,
  input wire busy_o,
  input wire unlocked_o
);
  // recent shift clock samples; a read bit may only move after a rise
  reg [7:0] sck_hist_ff;
  always @(posedge mclk_i) begin
    sck_hist_ff <= {sck_hist_ff[6:0], shift_clk_i};
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_off_desel: assert property ((!select_i)[*5] |-> !data_out_oe_o)
    else $error("output driven while deselected");
  a_oe_needs_select: assert property ($rose(data_out_oe_o) |-> $past(select_i))
    else $error("output enabled without select");
  a_power_quiet: assert property ((!supply_ok_i)[*5] |-> !data_out_oe_o && !unlocked_o)
    else $error("active while supply low");
  a_lock_on_drop: assert property ($fell(supply_ok_i) |-> ##[1:5] !unlocked_o)
    else $error("unlock latch kept over supply drop");
  a_prog_needs_unlock: assert property ($rose(busy_o) |-> $past(unlocked_o))
    else $error("programming started while locked");
  a_status_busy: assert property (busy_o && $past(busy_o, 4) && data_out_oe_o && $past(data_out_oe_o, 4)
    |-> !data_out_o)
    else $error("status not busy during programming");
  a_latch_held_busy: assert property (busy_o && $past(busy_o) && supply_ok_i |-> $stable(unlocked_o))
    else $error("instruction taken while busy");
  a_read_after_edge: assert property (data_out_oe_o && $past(data_out_oe_o) && $changed(data_out_o)
    && !busy_o && !$past(busy_o, 2) && !$past(busy_o, 3) |-> |sck_hist_ff)
    else $error("read bit moved without shift clock rise");
  c_prog: cover property ($rose(busy_o));
  c_unlock: cover property ($rose(unlocked_o));
  c_drive: cover property ($rose(data_out_oe_o));
endmodule
bind serial_eeprom serial_eeprom_monitor i_serial_eeprom_monitor (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .supply_ok_i(supply_ok_i), .select_i(select_i), .shift_clk_i(shift_clk_i), .data_out_o(data_out_o),
  .data_out_oe_o(data_out_oe_o), .busy_o(busy_o), .unlocked_o(unlocked_o));

// >>> eeprom_master.sv
// bus master model: select, shift clock and serial data at a 320 ns bit time
`timescale 1ns/1ps
module eeprom_master (
  output logic select_o,
  output logic sck_o,
  output logic din_o,
  input wire dout_i,
  input wire oe_i
);
  logic last_q;
  initial begin
    select_o = 1'b0;
    sck_o = 1'b0;
    din_o = 1'b0;
    last_q = 1'b0;
  end
  // select moves only with clock low
  task automatic sel(input logic on);
    select_o = on;
    if (!on)
      din_o = ~din_o;
    #320;
  endtask
  // bits msb first on rises; a released output line reads as a flipped level
  task automatic shift(input int n, input logic [63:0] v, output logic [63:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = v[i];
      #160;
      last_q = oe_i ? dout_i : ~last_q;
      r = {r[62:0], last_q};
      sck_o = 1'b1;
      #160;
      sck_o = 1'b0;
    end
  endtask
endmodule

// >>> serial_eeprom_tb_top.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
`include "serial_eeprom_defs.vh"
module serial_eeprom_tb_top;
  logic mclk_i, rst_n_i, supply_ok_i, org_word_i;
  wire select_i, shift_clk_i, data_in_i, data_out_o, data_out_oe_o, busy_o, unlocked_o;
  int failures = 0;
  int checks = 0;
  int seed = 24;
  int cycles = 0;
  int a;
  logic [63:0] r;
  logic [15:0] v;
  logic exp_unl;
  logic [15:0] exp_mem [0:1023];
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  serial_eeprom #(.PROG_CYCLES(400)) i_serial_eeprom (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .supply_ok_i(supply_ok_i), .select_i(select_i), .shift_clk_i(shift_clk_i), .data_in_i(data_in_i),
    .org_word_i(org_word_i), .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o), .busy_o(busy_o),
    .unlocked_o(unlocked_o));
  eeprom_master i_eeprom_master (.select_o(select_i), .sck_o(shift_clk_i), .din_o(data_in_i),
    .dout_i(data_out_o), .oe_i(data_out_oe_o));
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [63:0] expect_words(input int a, input int n);
    expect_words = '0;
    for (int i = 0; i < n; i++)
      expect_words = (expect_words << 16) | 64'(exp_mem[(a + i) % 1024]);
  endfunction
  // start bit, two op bits, address, then data
  task automatic frame(input logic [1:0] op, input int a, input int dv, input int dn, input logic keep);
    logic [63:0] w;
    w = ((({62'h1, op} << (org_word_i ? 10 : 11)) | 64'(a)) << dn) | 64'(dv);
    i_eeprom_master.sel(1'b1);
    i_eeprom_master.shift(3 + (org_word_i ? 10 : 11) + dn, w, r);
    if (!keep)
      i_eeprom_master.sel(1'b0);
  endtask
  task automatic rd(input int a, input int n);
    frame(`OP_READ, a, 0, 0, 1'b1);
    i_eeprom_master.shift(1 + n * (org_word_i ? 16 : 8), 0, r);
    i_eeprom_master.sel(1'b0);
  endtask
  task automatic status(input logic e);
    i_eeprom_master.sel(1'b1);
    i_eeprom_master.shift(1, 0, r);
    i_eeprom_master.sel(1'b0);
    check(r, 64'(e));
  endtask
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < lim) begin
      @(posedge mclk_i);
      // look at busy off the edge that updates it
      #3;
      k++;
    end
    check(64'(k < lim), 64'h1);
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    supply_ok_i = 1'b1;
    org_word_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #3 rst_n_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #3;
    // lock latch model: cleared by reset, supply drop and lock, set by unlock
    exp_unl = 1'b0;
    check(unlocked_o, exp_unl);
    frame(`OP_WRITE, 5, 16'h1234, 16, 1'b0);
    check(busy_o, exp_unl);
    frame(`OP_EXT, `EXT_UNLOCK << 8, 0, 0, 1'b0);
    exp_unl = 1'b1;
    check(unlocked_o, exp_unl);
    v = $random(seed);
    frame(`OP_EXT, `EXT_FILL << 8, v, 16, 1'b0);
    foreach (exp_mem[k]) exp_mem[k] = v;
    wait_idle(3000);
    // top address first so the stream must wrap to zero
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 1023 : $unsigned($random(seed)) % 1024;
      exp_mem[a] = $random(seed);
      frame(`OP_WRITE, a, exp_mem[a], 16, 1'b0);
      if (i == 0) begin
        status(1'b0);
        frame(`OP_EXT, `EXT_LOCK << 8, 0, 0, 1'b0);
        check({busy_o, unlocked_o}, 2'b11);
      end
      wait_idle(1000);
      status(1'b1);
      rd(a, 2);
      check(r, expect_words(a, 2));
    end
    frame(`OP_ERASE, a, 0, 0, 1'b0);
    exp_mem[a] = `ERASED_WORD;
    wait_idle(1000);
    rd(a, 1);
    check(r, expect_words(a, 1));
    // select dropped inside the data field
    i_eeprom_master.sel(1'b1);
    i_eeprom_master.shift(21, {3'b101, 10'd7, 8'hA5}, r);
    i_eeprom_master.sel(1'b0);
    check(busy_o, 0);
    rd(7, 1);
    check(r, expect_words(7, 1));
    frame(`OP_EXT, `EXT_CLEAR << 8, 0, 0, 1'b0);
    foreach (exp_mem[k]) exp_mem[k] = `ERASED_WORD;
    wait_idle(3000);
    rd(1022, 3);
    check(r, expect_words(1022, 3));
    @(posedge mclk_i);
    #3 org_word_i = 1'b0;
    a = $unsigned($random(seed)) % 2048;
    v = $random(seed);
    frame(`OP_WRITE, a, v[7:0], 8, 1'b0);
    wait_idle(1000);
    rd(a, 2);
    check(r, {v[7:0], 8'hFF});
    @(posedge mclk_i);
    #3 org_word_i = 1'b1;
    // idle and deselected before the supply drops
    wait_idle(1000);
    supply_ok_i = 1'b0;
    exp_unl = 1'b0;
    repeat (8) @(posedge mclk_i);
    #3;
    frame(`OP_EXT, `EXT_UNLOCK << 8, 0, 0, 1'b1);
    check({unlocked_o, data_out_oe_o}, {exp_unl, 1'b0});
    i_eeprom_master.sel(1'b0);
    supply_ok_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    #3;
    check({unlocked_o, data_out_oe_o}, {exp_unl, 1'b0});
    frame(`OP_EXT, `EXT_UNLOCK << 8, 0, 0, 1'b0);
    exp_unl = 1'b1;
    check(unlocked_o, exp_unl);
    frame(`OP_EXT, `EXT_LOCK << 8, 0, 0, 1'b0);
    exp_unl = 1'b0;
    check(unlocked_o, exp_unl);
    finish_test();
  end
endmodule
